// ===== src/cot_regs.v
// Notes on behaviour
// RQ1: Bit 7 reads comparator result, read-only.
// RQ2: Bit 6 selects normal or calibration mode.
// RQ3: Bit 5 picks calibration terminal, inverting/non-inverting.
// RQ4: Bits 4..0 offset trim, reset zero.
// RQ5: Mode and terminal bits reset zero, R/W.
// RQ6: Amplifier control bit 7 enables amplifier.
// RQ7: Amplifier bit 5 drives output onto pin.
// RQ8: Normal mode route field selects amplifier inputs.
// RQ9: Calibration codes 00/01 tie inputs to references.
// RQ10: Result writes ignored; trim updates in one cycle.
//
// Chosen here: the APB register port.
`include "cot_consts.vh"

module cot_regs #(
  parameter ADDR_W = 12,
  parameter NCMP   = 5
) (
  // Clock and reset
  input  wire              clk,
  input  wire              rst_n,
  // APB slave
  input  wire [ADDR_W-1:0] paddr,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [31:0]       pwdata,
  input  wire [3:0]        pstrb,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  // Raw comparator outputs, one bit each
  input  wire [NCMP-1:0]   cmpResultAsync,
  // Comparator trim controls, packed comparator 1 in low bits
  output reg  [NCMP-1:0]   cmpCalMode,
  output reg  [NCMP-1:0]   cmpCalTerminal,
  output reg  [5*NCMP-1:0] cmpOffsetTrim,
  // Amplifier controls
  output reg               ampOn,
  output reg               ampPinDrive,
  output reg  [1:0]        ampInputRoute,
  output reg               ampCalMode,
  output reg  [3:0]        ampPosSel,
  output reg  [3:0]        ampNegSel
);

  localparam [2:0] SLOT_AMP_CTRL = 3'h5;
  localparam [2:0] SLOT_AMP_CAL  = 3'h6;
  localparam [2:0] SLOT_NONE     = 3'h7;

  // Register map decode, shared by read and write paths
  function [2:0] decodeSlot;
    input [ADDR_W-1:0] addr;
    reg   [ADDR_W-3:0] idx;
    begin
      idx = addr[ADDR_W-1:2];
      if (addr[1:0] != 2'h0) begin
        decodeSlot = SLOT_NONE;
      end else if (idx == {{(ADDR_W-10){1'b0}}, `COT_IDX_CMP1}) begin
        decodeSlot = 3'h0;
      end else if (idx == {{(ADDR_W-10){1'b0}}, `COT_IDX_CMP2}) begin
        decodeSlot = 3'h1;
      end else if (idx == {{(ADDR_W-10){1'b0}}, `COT_IDX_CMP3}) begin
        decodeSlot = 3'h2;
      end else if (idx == {{(ADDR_W-10){1'b0}}, `COT_IDX_CMP4}) begin
        decodeSlot = 3'h3;
      end else if (idx == {{(ADDR_W-10){1'b0}}, `COT_IDX_CMP5}) begin
        decodeSlot = 3'h4;
      end else if (idx == {{(ADDR_W-10){1'b0}}, `COT_IDX_AMP_CTRL}) begin
        decodeSlot = SLOT_AMP_CTRL;
      end else if (idx == {{(ADDR_W-10){1'b0}}, `COT_IDX_AMP_CAL}) begin
        decodeSlot = SLOT_AMP_CAL;
      end else begin
        decodeSlot = SLOT_NONE;
      end
    end
  endfunction

  // Input routing decode; both modes use the same field
  function [7:0] routeSel;
    input       calMode;
    input [1:0] route;
    begin
      if (!calMode) begin
        case (route)
          `COT_ROUTE_0: routeSel = {`COT_POS_PIN,    `COT_NEG_GNDGAIN}; // RQ8
          `COT_ROUTE_1: routeSel = {`COT_POS_GND,    `COT_NEG_PINGAIN}; // RQ8
          `COT_ROUTE_2: routeSel = {`COT_POS_GND1K,  `COT_NEG_PINGAIN}; // RQ8
          default:      routeSel = {`COT_POS_PIN,    `COT_NEG_PIN};     // RQ8
        endcase
      end else begin
        case (route)
          `COT_ROUTE_0: routeSel = {`COT_POS_VTRIM,  `COT_NEG_VTRIM};   // RQ9
          `COT_ROUTE_1: routeSel = {`COT_POS_GND,    `COT_NEG_GNDGAIN}; // RQ9
          // Other calibration codes left open: all switches off
          default:      routeSel = {`COT_SEL_NONE,   `COT_SEL_NONE};
        endcase
      end
    end
  endfunction

  wire [2:0] slot;
  wire       setupPhase;
  wire       accessWrite;
  wire       laneWrite;
  wire       slotIsCmp;

  assign slot        = decodeSlot(paddr);
  assign setupPhase  = psel & ~penable;
  // Write lands at the access edge where pready is seen high
  assign accessWrite = psel & penable & pready & pwrite;
  // Registers sit in byte lane 0; other lanes hold nothing
  assign laneWrite   = accessWrite & pstrb[0];
  assign slotIsCmp   = (slot < 3'h5);

  // Comparator trim registers
  wire [8*NCMP-1:0] cmpReadAll;
  wire [NCMP-1:0]   cmpModeW;
  wire [NCMP-1:0]   cmpTermW;
  wire [5*NCMP-1:0] cmpTrimW;

  genvar gi;
  generate
    for (gi = 0; gi < NCMP; gi = gi + 1) begin : gCmp
      cot_cmp_trim uTrim (
        .clk         (clk),
        .rst_n       (rst_n),
        .wrEn        (laneWrite & slotIsCmp & (slot == gi)), // RQ10
        .wrData      (pwdata[7:0]),
        .resultAsync (cmpResultAsync[gi]),
        .calMode     (cmpModeW[gi]),
        .calTerminal (cmpTermW[gi]),
        .offsetTrim  (cmpTrimW[5*gi +: 5]),
        .readValue   (cmpReadAll[8*gi +: 8])
      );
    end
  endgenerate

  // Amplifier control and calibration storage
  reg       ampOn_reg;
  reg       ampPinDrive_reg;
  reg [1:0] ampRoute_reg;
  reg       ampCal_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ampOn_reg       <= `COT_RST_BIT;    // RQ6
      ampPinDrive_reg <= `COT_RST_BIT;    // RQ7
      ampRoute_reg    <= `COT_RST_ROUTE;  // RQ8
      ampCal_reg      <= `COT_RST_BIT;
    end else begin
      if (laneWrite && slot == SLOT_AMP_CTRL) begin
        ampOn_reg       <= pwdata[`COT_BIT_AMP_ON];                  // RQ6
        ampPinDrive_reg <= pwdata[`COT_BIT_AMP_PIN];                 // RQ7
        ampRoute_reg    <= pwdata[`COT_ROUTE_MSB:`COT_ROUTE_LSB];    // RQ8
      end
      if (laneWrite && slot == SLOT_AMP_CAL) begin
        ampCal_reg      <= pwdata[`COT_BIT_AMP_CAL];
      end
    end
  end

  // Read mux; unused bits of each register read as zero
  reg [7:0] readByte;
  always @* begin
    case (slot)
      3'h0, 3'h1, 3'h2, 3'h3, 3'h4: begin
        readByte = cmpReadAll[8*slot +: 8]; // RQ1
      end
      SLOT_AMP_CTRL: begin
        readByte = {ampOn_reg, 1'h0, ampPinDrive_reg, ampRoute_reg, 3'h0};
      end
      SLOT_AMP_CAL: begin
        readByte = {1'h0, ampCal_reg, 6'h00};
      end
      default: begin
        readByte = 8'h00;
      end
    endcase
  end

  // APB answer: captured in setup, presented in the first access cycle.
  // Zero wait states, so every transfer takes exactly two cycles.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'h0;
      prdata  <= 32'h00000000;
      pslverr <= 1'h0;
    end else begin
      pready <= setupPhase;
      if (setupPhase) begin
        prdata  <= pwrite ? 32'h00000000 : {24'h000000, readByte};
        pslverr <= (slot == SLOT_NONE);
      end else if (pready) begin
        // Drop answer after the completing edge so it cannot linger
        prdata  <= 32'h00000000;
        pslverr <= 1'h0;
      end
    end
  end

  // Output stage; every control leaves the block from a flip-flop
  wire [7:0] selNow;
  assign selNow = routeSel(ampCal_reg, ampRoute_reg);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmpCalMode     <= {NCMP{1'b0}};
      cmpCalTerminal <= {NCMP{1'b0}};
      cmpOffsetTrim  <= {(5*NCMP){1'b0}};
      ampOn          <= 1'h0;
      ampPinDrive    <= 1'h0;
      ampInputRoute  <= 2'h0;
      ampCalMode     <= 1'h0;
      ampPosSel      <= `COT_POS_PIN;
      ampNegSel      <= `COT_NEG_GNDGAIN;
    end else begin
      cmpCalMode     <= cmpModeW;   // RQ2
      cmpCalTerminal <= cmpTermW;   // RQ3
      cmpOffsetTrim  <= cmpTrimW;   // RQ4
      ampOn          <= ampOn_reg;        // RQ6
      ampPinDrive    <= ampPinDrive_reg;  // RQ7
      ampInputRoute  <= ampRoute_reg;
      ampCalMode     <= ampCal_reg;
      ampPosSel      <= selNow[7:4];  // RQ8
      ampNegSel      <= selNow[3:0];  // RQ9
    end
  end

endmodule

// ===== src/cot_consts.vh
`ifndef COT_CONSTS_VH
`define COT_CONSTS_VH

// Register indices; byte address is four times the index
`define COT_IDX_CMP1      8'he9
`define COT_IDX_CMP2      8'hea
`define COT_IDX_CMP3      8'heb
`define COT_IDX_CMP4      8'hec
`define COT_IDX_CMP5      8'hed
`define COT_IDX_AMP_CTRL  8'hee
`define COT_IDX_AMP_CAL   8'hef

// Comparator trim register fields
`define COT_BIT_RESULT    7
`define COT_BIT_MODE      6
`define COT_BIT_TERM      5
`define COT_TRIM_MSB      4
`define COT_TRIM_LSB      0

// Amplifier control register fields
`define COT_BIT_AMP_ON    7
`define COT_BIT_AMP_PIN   5
`define COT_ROUTE_MSB     4
`define COT_ROUTE_LSB     3

// Amplifier calibration register field
`define COT_BIT_AMP_CAL   6

// Reset values
`define COT_RST_BIT       1'h0
`define COT_RST_TRIM      5'h00
`define COT_RST_ROUTE     2'h0

// Input routing codes
`define COT_ROUTE_0       2'h0
`define COT_ROUTE_1       2'h1
`define COT_ROUTE_2       2'h2
`define COT_ROUTE_3       2'h3

// One-hot positive input selects: pin, ground, ground via 1k, trim reference
`define COT_POS_PIN       4'h1
`define COT_POS_GND       4'h2
`define COT_POS_GND1K     4'h4
`define COT_POS_VTRIM     4'h8
// One-hot negative input selects: ground+gain, pin+gain, pin direct, trim reference
`define COT_NEG_GNDGAIN   4'h1
`define COT_NEG_PINGAIN   4'h2
`define COT_NEG_PIN       4'h4
`define COT_NEG_VTRIM     4'h8
`define COT_SEL_NONE      4'h0

`endif

// ===== src/cot_cmp_trim.v
`include "cot_consts.vh"

module cot_cmp_trim (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Write port from the bus slave
  input  wire       wrEn,
  input  wire [7:0] wrData,
  // Raw comparator output from the analog side
  input  wire       resultAsync,
  // Trim controls
  output wire       calMode,
  output wire       calTerminal,
  output wire [4:0] offsetTrim,
  // Readback image
  output wire [7:0] readValue
);

  reg       calMode_reg;
  reg       calTerminal_reg;
  reg [4:0] offsetTrim_reg;
  reg       resultMeta_reg;
  reg       result_reg;

  // Two-stage synchroniser; comparator toggles freely vs clk
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resultMeta_reg <= 1'h0;
      result_reg     <= 1'h0;
    end else begin
      resultMeta_reg <= resultAsync;
      result_reg     <= resultMeta_reg;
    end
  end

  // Only writable fields load; result bit is ignored on write
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      calMode_reg     <= `COT_RST_BIT;   // RQ5
      calTerminal_reg <= `COT_RST_BIT;   // RQ5
      offsetTrim_reg  <= `COT_RST_TRIM;  // RQ4
    end else if (wrEn) begin
      calMode_reg     <= wrData[`COT_BIT_MODE];                  // RQ2
      calTerminal_reg <= wrData[`COT_BIT_TERM];                  // RQ3
      offsetTrim_reg  <= wrData[`COT_TRIM_MSB:`COT_TRIM_LSB];    // RQ4
    end
  end

  assign calMode     = calMode_reg;
  assign calTerminal = calTerminal_reg;
  assign offsetTrim  = offsetTrim_reg;

  // Result reads from the second synchroniser stage only
  assign readValue = {result_reg, calMode_reg, calTerminal_reg, offsetTrim_reg}; // RQ1

endmodule

// ===== verification/cot_regs_chk.sv
module cot_regs_chk #(
  parameter ADDR_W = 12,
  parameter NCMP   = 5
) (
  // Clock, reset and bus
  input logic              clk,
  input logic              rst_n,
  input logic [ADDR_W-1:0] paddr,
  input logic              psel,
  input logic              penable,
  input logic              pwrite,
  input logic [31:0]       pwdata,
  input logic [3:0]        pstrb,
  input logic [31:0]       prdata,
  input logic              pready,
  // Comparator and amplifier side
  input logic [NCMP-1:0]   cmpResultAsync,
  input logic [NCMP-1:0]   cmpCalMode,
  input logic [NCMP-1:0]   cmpCalTerminal,
  input logic [5*NCMP-1:0] cmpOffsetTrim,
  input logic              ampOn,
  input logic              ampPinDrive,
  input logic [1:0]        ampInputRoute,
  input logic              ampCalMode,
  input logic [3:0]        ampPosSel,
  input logic [3:0]        ampNegSel
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] live_reg;
  logic       wrCmp;
  logic       wrAmp;

  // Edges since reset, so synchroniser lag is not taken for a fault
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) live_reg <= 3'h0;
    else live_reg <= {live_reg[1:0], 1'b1};
  end

  // Completing write edges for comparator 1 and the amplifier
  assign wrCmp = psel && penable && pready && pwrite && pstrb[0] && paddr == 12'h3a4;
  assign wrAmp = psel && penable && pready && pwrite && pstrb[0] && paddr == 12'h3b8;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  // Outputs trail the stored field by one more edge through the output stage
  chk_cmp_write: assert property (wrCmp |-> ##2
    {cmpCalMode[0], cmpCalTerminal[0], cmpOffsetTrim[4:0]} == $past(pwdata[6:0], 2))
    else $error("trim write lost");
  chk_trim_hold: assert property (!(psel && pwrite) |-> ##2 $stable(cmpOffsetTrim))
    else $error("trim moved without write");
  chk_read_trim: assert property (pready && !pwrite && paddr == 12'h3a4 |->
    prdata[6:0] == {cmpCalMode[0], cmpCalTerminal[0], cmpOffsetTrim[4:0]})
    else $error("trim readback wrong");
  chk_result_read: assert property (live_reg[2] && psel && !penable && !pwrite
    && paddr == 12'h3a4 && $stable(cmpResultAsync[0])
    && $past(cmpResultAsync[0], 2) == cmpResultAsync[0]
    |=> prdata[7] == $past(cmpResultAsync[0]))
    else $error("result bit wrong");
  chk_amp_write: assert property (wrAmp |-> ##2 {ampOn, ampPinDrive, ampInputRoute}
    == {$past(pwdata[7], 2), $past(pwdata[5], 2), $past(pwdata[4:3], 2)})
    else $error("amp write lost");
  chk_route_norm: assert property (!ampCalMode |->
    {ampPosSel, ampNegSel} == 8'(32'h14422211 >> (8 * ampInputRoute)))
    else $error("normal routing wrong");
  chk_route_cal: assert property (ampCalMode && !ampInputRoute[1] |->
    {ampPosSel, ampNegSel} == (ampInputRoute[0] ? 8'h21 : 8'h88))
    else $error("calibration routing wrong");
endmodule

// ===== verification/cot_regs_tb.sv
module cot_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // Design ports and bench state
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, errFlag;
  logic        ampOn, ampPinDrive, ampCalMode;
  logic [1:0]  ampInputRoute;
  logic [3:0]  pstrb, ampPosSel, ampNegSel;
  logic [4:0]  cmpResultAsync, cmpCalMode, cmpCalTerminal;
  logic [11:0] paddr;
  logic [24:0] cmpOffsetTrim;
  logic [31:0] pwdata, prdata, rdat;
  int          fails, samples_checked;

  cot_regs i_dut (.*);

  // System clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Reset, then the scenarios in turn
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, pstrb, cmpResultAsync} = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_cmp;
    t_result;
    t_amp;
    t_refuse;
    wrap_up;
  end

  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                      input logic [3:0] s);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    // Strobes stay low on reads, as the bus requires
    pstrb <= w ? s : 4'h0;
    n = 0;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(pready, 1'b1);
    rdat = prdata;
    errFlag = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reset value, all mode/terminal pairs, trim extremes, result bit write
  task automatic t_cmp;
    logic [11:0] a;
    logic [7:0]  v;
    for (int i = 0; i < 5; i++) begin
      a = 12'h3a4 + 12'(4 * i);
      xfer(1'b0, a, 8'h00, 4'h1);
      chk(rdat, 0);
      for (int k = 0; k < 4; k++) begin
        v = {1'b1, 2'(k), k == 3 ? 5'h1f : 5'(i * 7 + k * 9)};
        xfer(1'b1, a, v, 4'h1);
        // Output stage adds one edge after the stored field
        @(posedge clk);
        @(negedge clk);
        chk({cmpCalMode[i], cmpCalTerminal[i], cmpOffsetTrim[5*i +: 5]}, v[6:0]);
        xfer(1'b0, a, 8'h00, 4'h1);
        chk(rdat, v[6:0]);
      end
    end
    $display("test cmp done");
  endtask

  // Result bits follow the inputs once synchronised
  task automatic t_result;
    logic [4:0] pat;
    for (int k = 0; k < 2; k++) begin
      pat = k ? 5'h0a : 5'h15;
      @(posedge clk);
      cmpResultAsync <= pat;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 5; i++) begin
        xfer(1'b0, 12'h3a4 + 12'(4 * i), 8'h00, 4'h1);
        chk(rdat[7], pat[i]);
      end
    end
    $display("test result done");
  endtask

  // Every route code in normal and calibration mode
  task automatic t_amp;
    logic [7:0]  v;
    logic [31:0] tbl;
    xfer(1'b0, 12'h3b8, 8'h00, 4'h1);
    chk(rdat, 0);
    for (int c = 0; c < 2; c++) begin
      xfer(1'b1, 12'h3bc, c ? 8'h40 : 8'h00, 4'h1);
      xfer(1'b0, 12'h3bc, 8'h00, 4'h1);
      chk(rdat, c ? 32'h40 : 32'h0);
      tbl = c ? 32'h00002188 : 32'h14422211;
      for (int r = 0; r < 4; r++) begin
        v = {r[0], 1'b0, r[1], 2'(r), 3'h0};
        xfer(1'b1, 12'h3b8, v, 4'h1);
        @(posedge clk);
        @(negedge clk);
        chk({ampCalMode, ampOn, ampPinDrive, ampInputRoute}, {c[0], v[7], v[5], v[4:3]});
        chk({ampPosSel, ampNegSel}, tbl[8*r +: 8]);
        xfer(1'b0, 12'h3b8, 8'h00, 4'h1);
        chk(rdat, v);
      end
    end
    $display("test amp done");
  endtask

  // Unmapped read and a write with its byte strobe off
  task automatic t_refuse;
    xfer(1'b0, 12'h3c0, 8'h00, 4'h1);
    chk({errFlag, rdat[30:0]}, 32'h80000000);
    xfer(1'b1, 12'h3a4, 8'h15, 4'h0);
    xfer(1'b0, 12'h3a4, 8'h00, 4'h1);
    chk({errFlag, rdat[30:0]}, 32'h7f);
    $display("test refuse done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
endmodule

bind cot_regs cot_regs_chk #(.ADDR_W(ADDR_W), .NCMP(NCMP)) i_chk (.*);
